// ==== gpsr_top.sv ====
// module: joystick port pin status, start pulse, position counters and event flags over apb
//
// Contract
// - pin status register readable in every mode
// - write to pin status starts axis pulse
// - that write clears counters in extended mode
// - bits 7..4 show raw button pin levels
// - bits 3..0 show axis pin states
// - flags: write one clears, zero keeps
// - counter high byte read clears its ready flag
// - flags set only in extended mode
// - bits 7..4 latch selected button events
// - bits 3..0 set when counter readable
// - all flags reset to zero
// - extended mode only while control bit0 set
// - counter saturates at full count, overflow
// - button events are polarity-selected edges
`timescale 1ns/100ps
module gpsr_top #(
  parameter int ADDR_W    = 8,
  parameter int CNT_W     = 16,
  parameter int PULSE_CYC = gpsr_pkg::PULSE_CYC
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // interrupt
  output logic                   irq,
  // joystick pins: buttons b1 b0 of b, b1 b0 of a; axes by bx ay ax
  input  wire logic [3:0]        button_in,
  input  wire logic [3:0]        axis_in,
  output logic      [3:0]        axis_out,
  output logic      [3:0]        axis_oe
);

  typedef struct packed {
    logic [2:0]            ctrl;
    logic [3:0]            pol;
    logic [7:0]            flags;
    logic [7:0]            mask;
    logic [3:0]            btn_s1;
    logic [3:0]            btn_s2;
    logic [3:0]            btn_d;
    logic [3:0]            ax_s1;
    logic [3:0]            ax_s2;
    logic [15:0]           pulse_cnt;
    logic [7:0]            div_cnt;
    logic [1:0]            half;
    logic [3:0]            done;
    logic                  meas;
    logic [3:0][CNT_W-1:0] cnt;
    logic [3:0]            ax_oe;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  irq;
  } gpsr_state_s;

  gpsr_state_s st_reg;
  gpsr_state_s st_next;

  localparam logic [15:0] PULSE_LAST = 16'(PULSE_CYC - 1);
  localparam logic [7:0]  TICK_LAST  = 8'(gpsr_pkg::TICK_CYC - 1);

  logic [5:0] idx;
  logic       aligned;
  logic       setup;
  logic       access;
  logic       wr_acc;
  logic       rd_acc;
  logic       mapped;
  logic       enh;
  logic       tick;
  logic [3:0] dev_tick;
  logic [3:0] btn_evt;
  logic [7:0] set_bits;
  logic [7:0] clr_bits;
  logic [2:0] cnt_sel;
  logic [CNT_W-1:0] cnt_word;

  assign idx     = paddr[7:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign mapped  = aligned && (idx <= gpsr_pkg::IDX_MASK) && (idx != gpsr_pkg::IDX_HOLE);
  assign setup   = psel && !penable;
  assign access  = psel && penable && st_reg.pready;
  assign wr_acc  = access && pwrite && !st_reg.pslverr;
  assign rd_acc  = access && !pwrite && !st_reg.pslverr;
  assign enh     = st_reg.ctrl[gpsr_pkg::CTRL_ENH_BIT];
  assign tick    = (st_reg.div_cnt == TICK_LAST);
  assign cnt_sel = 3'(idx - gpsr_pkg::IDX_CNT_LO);
  assign cnt_word = st_reg.cnt[cnt_sel[2:1]];

  always_comb begin
    st_next = st_reg;
    // pin synchronisers; pin status reads these, cleared to zero by reset
    st_next.btn_s1 = button_in;
    st_next.btn_s2 = st_reg.btn_s1;
    st_next.btn_d  = st_reg.btn_s2;
    st_next.ax_s1  = axis_in;
    st_next.ax_s2  = st_reg.ax_s1;

    // polarity 1 selects rising edge, 0 falling edge
    for (int i = 0; i < 4; i++) begin
      btn_evt[i] = st_reg.pol[i] ? (st_reg.btn_s2[i] && !st_reg.btn_d[i])
                                 : (!st_reg.btn_s2[i] && st_reg.btn_d[i]);
    end

    // 1 MHz base tick, halved per device by prescale
    st_next.div_cnt = tick ? 8'h00 : 8'(st_reg.div_cnt + 8'h01);
    if (tick) begin
      st_next.half = ~st_reg.half;
    end
    for (int i = 0; i < 4; i++) begin
      dev_tick[i] = tick && (!st_reg.ctrl[gpsr_pkg::CTRL_PRE_A_BIT + i / 2]
                             || st_reg.half[i / 2]);
    end

    // start pulse counted up to PULSE_LAST, then measurement in extended mode
    set_bits = 8'h00;
    if (st_reg.ax_oe != 4'h0) begin
      if (st_reg.pulse_cnt == PULSE_LAST) begin
        st_next.ax_oe     = 4'h0;
        st_next.pulse_cnt = 16'h0000;
        st_next.meas      = enh;
      end else begin
        st_next.pulse_cnt = 16'(st_reg.pulse_cnt + 16'h0001);
      end
    end else if (st_reg.meas && enh) begin
      for (int i = 0; i < 4; i++) begin
        if (!st_reg.done[i]) begin
          if (st_reg.ax_s2[i]) begin
            st_next.done[i] = 1'b1;
            set_bits[i]     = 1'b1;
          end else if (dev_tick[i] && st_reg.cnt[i] != gpsr_pkg::CNT_FULL) begin
            st_next.cnt[i] = CNT_W'(st_reg.cnt[i] + 1'b1);
          end
          // at full count the counter holds: overflow for software to judge
        end
      end
      if (st_next.done == 4'hf) begin
        st_next.meas = 1'b0;
      end
    end else begin
      st_next.meas = 1'b0;
    end
    set_bits[7:4] = btn_evt;
    if (!enh) begin
      set_bits = 8'h00;
    end

    // apb: answer registered in setup, action at access edge
    st_next.pready  = setup;
    st_next.pslverr = setup && !mapped;
    if (setup) begin
      st_next.prdata = 32'h0000_0000;
      if (mapped && !pwrite) begin
        case (idx)
          gpsr_pkg::IDX_CTRL:  st_next.prdata[2:0] = st_reg.ctrl;
          gpsr_pkg::IDX_LEVEL: st_next.prdata[7:0] = {st_reg.btn_s2, st_reg.ax_s2};
          gpsr_pkg::IDX_FLAGS: st_next.prdata[7:0] = st_reg.flags;
          gpsr_pkg::IDX_POL:   st_next.prdata[3:0] = st_reg.pol;
          gpsr_pkg::IDX_MASK:  st_next.prdata[7:0] = st_reg.mask;
          default: begin
            st_next.prdata[7:0] = cnt_sel[0] ? cnt_word[15:8] : cnt_word[7:0];
          end
        endcase
      end
    end

    clr_bits = 8'h00;
    if (wr_acc) begin
      case (idx)
        gpsr_pkg::IDX_CTRL:  st_next.ctrl = pwdata[2:0];
        gpsr_pkg::IDX_LEVEL: begin
          // only effect: start a reading, counters cleared in extended mode; ctrl, pol and mask keep their bits
          st_next.ax_oe     = 4'hf;
          st_next.pulse_cnt = 16'h0000;
          st_next.meas      = 1'b0;
          if (enh) begin
            st_next.cnt  = '0;
            st_next.done = 4'h0;
          end
        end
        gpsr_pkg::IDX_FLAGS: clr_bits = pwdata[7:0];
        gpsr_pkg::IDX_POL:   st_next.pol  = pwdata[3:0];
        gpsr_pkg::IDX_MASK:  st_next.mask = pwdata[7:0];
        default: ;
      endcase
    end
    if (rd_acc && idx >= gpsr_pkg::IDX_CNT_LO && idx <= gpsr_pkg::IDX_CNT_HI && cnt_sel[0]) begin
      clr_bits[cnt_sel[2:1]] = 1'b1;
    end
    // set wins over a clear in the same cycle
    st_next.flags = (st_reg.flags & ~clr_bits) | set_bits;
    st_next.irq   = |(st_next.flags & st_next.mask);
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg        <= '0;
      st_reg.ctrl   <= gpsr_pkg::CTRL_RST;
      st_reg.pol    <= gpsr_pkg::POL_RST;
      st_reg.flags  <= gpsr_pkg::FLAGS_RST;
      st_reg.mask   <= gpsr_pkg::MASK_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata   = st_reg.prdata;
  assign pready   = st_reg.pready;
  assign pslverr  = st_reg.pslverr;
  assign irq      = st_reg.irq;
  assign axis_oe  = st_reg.ax_oe;
  assign axis_out = st_reg.ax_oe & 4'h0;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // start pulse
  a_pulse_start: assert property (wr_acc && idx == gpsr_pkg::IDX_LEVEL |=> axis_oe == 4'hf)
    else $error("write to pin status did not start pulse");

  a_start_all: assert property ($rose(axis_oe[0]) |-> axis_oe == 4'hf)
    else $error("start pulse not on all axis pins");

  a_drive_low: assert property (axis_oe != 4'h0 |-> axis_out == 4'h0)
    else $error("axis pin driven high during pulse");

  a_pulse_len: assert property ($fell(axis_oe[0]) |-> $past(st_reg.pulse_cnt) == PULSE_LAST)
    else $error("pulse length wrong");

  a_pulse_idle: assert property (axis_oe == 4'h0 |-> st_reg.pulse_cnt == 16'h0000)
    else $error("pulse counter not idle");

  a_counter_init: assert property (wr_acc && idx == gpsr_pkg::IDX_LEVEL && enh
                                   |=> st_reg.cnt == '0)
    else $error("counters not cleared by start write");

  // pin status register
  a_level_read: assert property (setup && !pwrite && mapped && idx == gpsr_pkg::IDX_LEVEL
                                 |=> prdata[7:4] == $past(st_reg.btn_s2)
                                     && prdata[3:0] == $past(st_reg.ax_s2))
    else $error("pin status read wrong");

  a_level_no_store: assert property (wr_acc && idx == gpsr_pkg::IDX_LEVEL
                                     |=> $stable(st_reg.mask) && $stable(st_reg.pol)
                                         && $stable(st_reg.ctrl))
    else $error("pin status write changed a register");

  // event and ready flags
  a_w1c_clear: assert property (wr_acc && idx == gpsr_pkg::IDX_FLAGS && pwdata[0] && !set_bits[0]
                                |=> !st_reg.flags[0])
    else $error("write one did not clear flag");

  a_w0_keep: assert property (wr_acc && idx == gpsr_pkg::IDX_FLAGS && !pwdata[5] && st_reg.flags[5]
                              |=> st_reg.flags[5])
    else $error("write zero changed flag");

  a_read_clears: assert property (rd_acc && idx == 6'h05 && !set_bits[0]
                                  |=> !st_reg.flags[0])
    else $error("counter read left ready flag");

  a_legacy_quiet: assert property ($rose(st_reg.flags[4]) |-> $past(enh))
    else $error("flag set outside extended mode");

  a_no_meas_legacy: assert property (!enh |=> !st_reg.meas)
    else $error("measurement running outside extended mode");

  a_button_latch: assert property (enh && btn_evt[1] |=> st_reg.flags[5])
    else $error("button event not latched");

  a_edge_select: assert property (!st_reg.pol[0] && st_reg.btn_s2[0] && !st_reg.btn_d[0]
                                  |-> !btn_evt[0])
    else $error("event on wrong edge");

  a_ready_set: assert property ($rose(st_reg.done[2]) |-> st_reg.flags[2])
    else $error("ready flag missing on axis stop");

  // position counters
  a_count_frozen: assert property (st_reg.done[0] && !wr_acc |=> $stable(st_reg.cnt[0]))
    else $error("counter moved after axis stop");

  a_count_hold: assert property (st_reg.cnt[0] == gpsr_pkg::CNT_FULL && !wr_acc
                                 |=> st_reg.cnt[0] == gpsr_pkg::CNT_FULL)
    else $error("full counter did not hold");

  a_overflow_wait: assert property (st_reg.cnt[0] == gpsr_pkg::CNT_FULL && !st_reg.ax_s2[0]
                                    && !st_reg.done[0] |=> !st_reg.done[0])
    else $error("overflowed counter stopped without axis high");

  a_tick_wrap: assert property (tick |=> st_reg.div_cnt == 8'h00)
    else $error("tick divider did not wrap");

  // bus answer and interrupt
  a_apb_wait: assert property (setup |=> pready ##1 !pready)
    else $error("apb answer timing wrong");

  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");

  a_err_pair: assert property (pslverr |-> pready)
    else $error("pslverr without pready");

  a_unmapped_read: assert property (setup && !mapped |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");

  a_irq_level: assert property (irq == |(st_reg.flags & st_reg.mask))
    else $error("interrupt level wrong");

  a_irq_masked: assert property (st_reg.mask == 8'h00 |-> !irq)
    else $error("interrupt with all sources masked");

  c_start: cover property (wr_acc && idx == gpsr_pkg::IDX_LEVEL && enh);
  c_ready: cover property ($rose(st_reg.flags[0]));
  c_button: cover property ($rose(st_reg.flags[7]));
  c_irq: cover property ($rose(irq));
  c_prescale: cover property (dev_tick[0] && st_reg.ctrl[gpsr_pkg::CTRL_PRE_A_BIT]);

endmodule

// ==== gpsr_pkg.sv ====
// package: register map, field layout and timing constants of the joystick port status block
package gpsr_pkg;
  localparam logic [5:0] IDX_CTRL   = 6'h00;
  localparam logic [5:0] IDX_LEVEL  = 6'h01;
  localparam logic [5:0] IDX_FLAGS  = 6'h02;
  localparam logic [5:0] IDX_HOLE   = 6'h03;
  localparam logic [5:0] IDX_CNT_LO = 6'h04;
  localparam logic [5:0] IDX_CNT_HI = 6'h0b;
  localparam logic [5:0] IDX_POL    = 6'h0c;
  localparam logic [5:0] IDX_MASK   = 6'h0d;
  localparam int CTRL_ENH_BIT       = 0;
  localparam int CTRL_PRE_A_BIT     = 1;
  localparam int CTRL_PRE_B_BIT     = 2;
  localparam int BTN_LSB            = 4;
  localparam logic [2:0] CTRL_RST   = 3'h0;
  localparam logic [3:0] POL_RST    = 4'h0;
  localparam logic [7:0] FLAGS_RST  = 8'h00;
  localparam logic [7:0] MASK_RST   = 8'h00;
  localparam logic [15:0] CNT_FULL  = 16'hffff;
  localparam int CLK_NS             = 5;
  localparam int TICK_NS            = 1000;
  localparam int PULSE_NS           = 10000;
  localparam int TICK_CYC           = TICK_NS / CLK_NS;
  localparam int PULSE_CYC          = PULSE_NS / CLK_NS;
endpackage

// ==== gpsr_joy_model.sv ====
// joystick partner: axis lines recharge after a per-axis delay once released
`timescale 1ns/100ps
module gpsr_joy_model #(
  parameter int DLY = 1000
) (
  // clock
  input  wire logic       ref_clk,
  // axis pins
  input  wire logic [3:0] axis_oe,
  output logic      [3:0] axis_in = 4'hf
);
  int cnt [4] = '{4{100000}};
  // held low while pulled, charged after (i+1)*DLY cycles
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) begin
      cnt[i] <= axis_oe[i] ? 0 : cnt[i] + 1;
      axis_in[i] <= !axis_oe[i] && cnt[i] >= DLY * (i + 1);
    end
  end
endmodule

// ==== gpsr_top_tb.sv ====
// self-checking bench for the joystick port status block
`timescale 1ns/100ps
module gpsr_top_tb;
  logic        ref_clk = 0;
  logic        rst_n   = 0;
  logic        psel    = 0;
  logic        penable = 0;
  logic        pwrite  = 0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [3:0]  button_in = 4'ha;
  logic [3:0]  axis_in;
  logic [3:0]  axis_out;
  logic [3:0]  axis_oe;
  int          n_errors = 0;
  int          n_checks = 0;
  int          cyc      = 0;

  gpsr_top #(.PULSE_CYC(20)) i_gpsr_top (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .button_in(button_in),
    .axis_in(axis_in), .axis_out(axis_out), .axis_oe(axis_oe));
  gpsr_joy_model i_gpsr_joy_model (.ref_clk(ref_clk), .axis_oe(axis_oe), .axis_in(axis_in));

  always #2.5 ref_clk = ~ref_clk;

  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc > 60000) begin
      n_errors++;
      test_done();
    end
  end

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one apb transfer, idle cycle after
  task automatic apb(logic wr, logic [5:0] idx, logic [31:0] wd, logic err = 1'b0);
    int t;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge ref_clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    rd = prdata;
    chk("pslverr", 32'(err), 32'(pslverr));
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  // read until masked value matches, bounded
  task automatic poll(logic [5:0] idx, logic [7:0] msk, logic [7:0] val);
    int t;
    t = 0;
    do begin
      apb(1'b0, idx, 32'h0);
      t++;
    end while ((rd[7:0] & msk) !== val && t < 2000);
    chk("poll", 32'(val), 32'(rd[7:0] & msk));
  endtask

  task automatic t_legacy;
    apb(1'b0, gpsr_pkg::IDX_FLAGS, 32'h0);
    chk("flags reset", 32'h0, rd);
    apb(1'b0, gpsr_pkg::IDX_LEVEL, 32'h0);
    chk("level idle", 32'h0000_00af, rd);
    apb(1'b0, gpsr_pkg::IDX_HOLE, 32'h0, 1'b1);
    apb(1'b1, gpsr_pkg::IDX_LEVEL, 32'h0000_00ff);
    #1;
    chk("axis_oe", 32'hf, 32'(axis_oe));
    chk("axis_out", 32'h0, 32'(axis_out));
    repeat (8) @(posedge ref_clk);
    apb(1'b0, gpsr_pkg::IDX_LEVEL, 32'h0);
    chk("level pulse", 32'h0000_00a0, rd);
    poll(gpsr_pkg::IDX_LEVEL, 8'hff, 8'haf);
    // button edges while in legacy mode must not latch
    button_in <= 4'h5;
    repeat (6) @(posedge ref_clk);
    button_in <= 4'ha;
    repeat (6) @(posedge ref_clk);
    apb(1'b0, gpsr_pkg::IDX_FLAGS, 32'h0);
    chk("flags legacy", 32'h0, rd);
  endtask

  task automatic t_extended;
    int lo;
    for (int pass = 0; pass < 2; pass++) begin
      // pass 0 halves device b, pass 1 halves device a
      apb(1'b1, gpsr_pkg::IDX_CTRL, pass == 0 ? 32'h5 : 32'h3);
      apb(1'b1, gpsr_pkg::IDX_LEVEL, 32'h0);
      poll(gpsr_pkg::IDX_FLAGS, 8'h0f, 8'h0f);
      for (int i = 0; i < 4; i++) begin
        lo = (i + 1) * 1000 / (((i < 2) == (pass == 1)) ? 400 : 200) - 1;
        apb(1'b0, 6'(gpsr_pkg::IDX_CNT_LO + 2 * i), 32'h0);
        chk("count", 32'h1, 32'(rd >= lo && rd <= lo + 2));
        apb(1'b0, 6'(gpsr_pkg::IDX_CNT_LO + 2 * i + 1), 32'h0);
        chk("count hi", 32'h0, rd);
      end
      apb(1'b0, gpsr_pkg::IDX_FLAGS, 32'h0);
      chk("ready cleared", 32'h0, rd & 32'h0f);
    end
  endtask

  task automatic t_buttons;
    apb(1'b1, gpsr_pkg::IDX_POL, 32'h1);
    apb(1'b1, gpsr_pkg::IDX_MASK, 32'h10);
    button_in <= 4'hb;
    poll(gpsr_pkg::IDX_FLAGS, 8'hf0, 8'h10);
    chk("irq on", 32'h1, 32'(irq));
    button_in <= 4'h9;
    poll(gpsr_pkg::IDX_FLAGS, 8'hf0, 8'h30);
    apb(1'b1, gpsr_pkg::IDX_MASK, 32'h0);
    chk("irq masked", 32'h0, 32'(irq));
    apb(1'b1, gpsr_pkg::IDX_MASK, 32'h10);
    apb(1'b1, gpsr_pkg::IDX_FLAGS, 32'h10);
    apb(1'b0, gpsr_pkg::IDX_FLAGS, 32'h0);
    chk("w1c", 32'h20, rd);
    chk("irq cleared", 32'h0, 32'(irq));
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_legacy();
    t_extended();
    t_buttons();
    test_done();
  end
endmodule
